// file: logic/sbm_pkg.sv
`default_nettype none
package sbm_pkg;
  // port geometry: 32-bit data, byte granules, so address starts at bit 2
  localparam int DATA_W   = 32;
  localparam int GRAN_W   = 8;
  localparam int SEL_W    = DATA_W / GRAN_W;
  localparam int ADR_HI   = 31;
  localparam int ADR_LO   = 2;
  localparam int ADR_W    = ADR_HI - ADR_LO + 1;
  localparam int TGA_W    = 2;
  localparam int TGD_W    = 4;
  localparam int TGC_W    = 2;
  localparam int LEN_W    = 4;
  localparam int RETRY_MAX = 3;
  localparam int RETRY_W  = 2;
  // cycle tag codes
  localparam logic [1:0] TGC_SINGLE = 2'h0;
  localparam logic [1:0] TGC_BLOCK  = 2'h1;
  localparam logic [1:0] TGC_RMW    = 2'h2;
  // completion status codes
  localparam logic [1:0] ST_OK    = 2'h0;
  localparam logic [1:0] ST_ERR   = 2'h1;
  localparam logic [1:0] ST_RETRY = 2'h2;
  typedef enum logic [1:0] {SBM_IDLE, SBM_XFER, SBM_BACKOFF} sbm_state_t;
endpackage : sbm_pkg
`default_nettype wire

// file: logic/sbm_par.sv
`timescale 1ns/1ps
`default_nettype none
// even parity per byte lane, registered so the data tag lines up with registered data
module sbm_par (
  input  wire logic                    clk,
  input  wire logic                    rst_ok,
  input  wire logic                    load,
  input  wire logic [sbm_pkg::DATA_W-1:0] data,
  output logic      [sbm_pkg::TGD_W-1:0]  par_q
);
  import sbm_pkg::*;
  logic [TGD_W-1:0] par_d;
  // one parity bit per granule
  always_comb begin
    for (int i = 0; i < TGD_W; i++) begin
      par_d[i] = ^data[i*GRAN_W +: GRAN_W];
    end
  end
  // hold value when not loading
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      par_q <= '0;
    end else if (load) begin
      par_q <= par_d;
    end
  end
endmodule : sbm_par
`default_nettype wire

// file: logic/sbm_master.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: all bus signals active high; board reset low is inverted before use (here it is not inverted: rst_ok stays low active)
// R2: every bus output comes straight from a clocked register
// R3: far side keeps inputs stable before the sampling edge
// R4: data arrays are port width, never wider than sixty-four bits
// R5: reset restarts the interface and forces the state machine idle
// R6: reset only needs to cover the bus interface logic
// R7: data tags travel with data and are valid under strobe
// R8: acknowledge ends the current transfer normally
// R9: address low index set by 32-bit byte granules: bits n..2
// R10: cycle rises with first transfer, holds through the last, block included
// R11: asserted cycle doubles as bus request to the arbiter
// R12: while stall is high the pending transfer stays presented
// R13: error ends the cycle abnormally; reported to the user
// R14: lock held across a cycle keeps the bus for this master
// R15: retry ends the attempt; master backs off then retries the cycle
// R16: one select bit per byte lane marks valid data lanes
// R17: strobe marks a valid transfer and qualifies the other signals
// R18: slave answers every strobe with exactly one termination
// R19: address tag valid whenever strobe qualifies the address
// R20: cycle tag describes the whole cycle, qualified by cycle
// R21: write enable low for reads, high for writes, whole cycle
// R22: interface initialises after reset edge and stays until release edge
// R23: strobe and cycle held low during reset
// R24: transfer signals frozen while strobe waits for termination
module sbm_master (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // user request side
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic                          req_we,
  input  wire logic [sbm_pkg::ADR_W-1:0]     req_adr,
  input  wire logic [sbm_pkg::DATA_W-1:0]    req_dat,
  input  wire logic [sbm_pkg::SEL_W-1:0]     req_sel,
  input  wire logic [sbm_pkg::TGA_W-1:0]     req_tga,
  input  wire logic [sbm_pkg::LEN_W-1:0]     req_len,
  input  wire logic                          req_lock,
  input  wire logic                          pipe_mode,
  output logic                               done_valid,
  output logic      [1:0]                    done_status,
  output logic      [sbm_pkg::DATA_W-1:0]    done_dat,
  output logic      [sbm_pkg::TGD_W-1:0]     done_tgd,
  // bus side
  input  wire logic [sbm_pkg::DATA_W-1:0]    dat_i,
  input  wire logic [sbm_pkg::TGD_W-1:0]     tgd_i,
  input  wire logic                          ack_i,
  input  wire logic                          err_i,
  input  wire logic                          rty_i,
  input  wire logic                          stall_i,
  output logic      [sbm_pkg::DATA_W-1:0]    dat_o,
  output logic      [sbm_pkg::TGD_W-1:0]     tgd_o,
  output logic      [sbm_pkg::ADR_HI:sbm_pkg::ADR_LO] adr_o,
  output logic      [sbm_pkg::SEL_W-1:0]     sel_o,
  output logic      [sbm_pkg::TGA_W-1:0]     tga_o,
  output logic      [sbm_pkg::TGC_W-1:0]     tgc_o,
  output logic                               cyc_o,
  output logic                               stb_o,
  output logic                               we_o,
  output logic                               lock_o
);
  import sbm_pkg::*;

  typedef struct packed {
    sbm_state_t           st;
    logic [DATA_W-1:0]    dat;
    logic [ADR_W-1:0]     adr;
    logic [SEL_W-1:0]     sel;
    logic [TGA_W-1:0]     tga;
    logic [TGC_W-1:0]     tgc;
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic                 lock;
    logic                 pipe;
    logic [LEN_W-1:0]     left;   // transfers still to issue
    logic [LEN_W-1:0]     pend;   // terminations still owed
    logic [RETRY_W-1:0]   retries;
    logic                 dv;
    logic [1:0]           dst;
    logic [DATA_W-1:0]    rdat;
    logic [TGD_W-1:0]     rtgd;
    // saved start of cycle, for retry replay
    logic [ADR_W-1:0]     adr0;
    logic [LEN_W-1:0]     len0;
  } sbm_regs_t;

  sbm_regs_t s_q;
  sbm_regs_t s_d;
  logic      rst_s1_q;
  logic      rst_ok;
  logic      done_sig;
  logic      accept;

  // release reset through two flops; board reset is low active and stays low active here as rst_ok
  always_ff @(posedge clk or negedge rst_n) begin // see R1
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_ok   <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_ok   <= rst_s1_q;
    end
  end

  // a transfer is accepted once strobe is seen, without stall in pipelined mode
  assign accept   = s_q.stb && (!s_q.pipe || !stall_i); // see R12
  assign done_sig = ack_i || err_i || rty_i;

  // main sequencer; inputs are same-clock logic so they are read directly
  always_comb begin
    s_d    = s_q;
    s_d.dv = 1'b0;
    case (s_q.st)
      SBM_IDLE: begin
        if (req_valid) begin
          s_d.st    = SBM_XFER;
          s_d.cyc   = 1'b1;                  // see R10 R11
          s_d.stb   = 1'b1;                  // see R17
          s_d.we    = req_we;                // see R21
          s_d.adr   = req_adr;               // see R9
          s_d.adr0  = req_adr;
          s_d.dat   = req_dat;
          s_d.sel   = req_sel;               // see R16
          s_d.tga   = req_tga;               // see R19
          s_d.lock  = req_lock;              // see R14
          s_d.pipe  = pipe_mode;
          s_d.len0  = req_len;
          s_d.left  = req_len;
          s_d.pend  = '0;
          s_d.tgc   = req_lock ? TGC_RMW : ((req_len != '0) ? TGC_BLOCK : TGC_SINGLE); // see R20
        end
      end
      SBM_XFER: begin
        // pipelined: issue next beat as soon as the slave takes one
        if (accept) begin
          if (s_q.pipe) begin
            s_d.pend = s_q.pend + LEN_W'(1);
            if (s_q.left == '0) begin
              s_d.stb = 1'b0;
            end else begin
              s_d.left = s_q.left - LEN_W'(1);
              s_d.adr  = s_q.adr + ADR_W'(1);
            end
          end
        end
        if (done_sig) begin                  // see R18
          if (s_q.pipe) begin
            s_d.pend = (accept ? s_q.pend + LEN_W'(1) : s_q.pend) - LEN_W'(1);
          end
          s_d.rdat = dat_i;
          s_d.rtgd = tgd_i;                  // see R7
          if (err_i) begin                   // see R13
            s_d.st  = SBM_IDLE;
            s_d.cyc = 1'b0;
            s_d.stb = 1'b0;
            s_d.lock = 1'b0;
            s_d.dv  = 1'b1;
            s_d.dst = ST_ERR;
          end else if (rty_i) begin          // see R15
            s_d.cyc = 1'b0;
            s_d.stb = 1'b0;
            s_d.lock = 1'b0;
            if (s_q.retries == RETRY_W'(RETRY_MAX)) begin
              s_d.st  = SBM_IDLE;
              s_d.dv  = 1'b1;
              s_d.dst = ST_RETRY;
            end else begin
              s_d.st      = SBM_BACKOFF;
              s_d.retries = s_q.retries + RETRY_W'(1);
            end
          end else begin                     // see R8
            s_d.dv  = 1'b1;
            s_d.dst = ST_OK;
            if (!s_q.pipe) begin
              if (s_q.left == '0) begin
                s_d.st  = SBM_IDLE;
                s_d.cyc = 1'b0;
                s_d.stb = 1'b0;
                s_d.lock = 1'b0;
              end else begin
                s_d.left = s_q.left - LEN_W'(1);
                s_d.adr  = s_q.adr + ADR_W'(1);
              end
            end else if (s_d.pend == '0 && !s_d.stb) begin
              s_d.st   = SBM_IDLE;
              s_d.cyc  = 1'b0;
              s_d.lock = 1'b0;
            end
          end
          if (s_d.st == SBM_IDLE) begin
            s_d.retries = '0;
          end
        end
      end
      SBM_BACKOFF: begin
        // one idle cycle with cycle low lets the arbiter regrant, then replay
        s_d.st   = SBM_XFER;
        s_d.cyc  = 1'b1;
        s_d.stb  = 1'b1;
        s_d.lock = s_q.tgc == TGC_RMW;
        s_d.adr  = s_q.adr0;
        s_d.left = s_q.len0;
        s_d.pend = '0;
      end
      default: begin
        s_d.st = SBM_IDLE;
      end
    endcase
  end

  // whole state resets synchronously to the released reset copy
  always_ff @(posedge clk) begin // see R5 R6 R22 R23
    if (!rst_ok) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // parity data tag for write data, loaded with the data
  sbm_par u_par (
    .clk    (clk),
    .rst_ok (rst_ok),
    .load   (s_q.st == SBM_IDLE && req_valid),
    .data   (req_dat),
    .par_q  (tgd_o)
  );

  // bus outputs other than tgd_o come directly from the state register
  assign dat_o       = s_q.dat;              // see R2 R4
  assign adr_o       = s_q.adr;
  assign sel_o       = s_q.sel;
  assign tga_o       = s_q.tga;
  assign tgc_o       = s_q.tgc;
  assign cyc_o       = s_q.cyc;
  assign stb_o       = s_q.stb;
  assign we_o        = s_q.we;
  assign lock_o      = s_q.lock;
  assign req_ready   = s_q.st == SBM_IDLE;
  assign done_valid  = s_q.dv;
  assign done_status = s_q.dst;
  assign done_dat    = s_q.rdat;
  assign done_tgd    = s_q.rtgd;

  // assertions
  a_rst_quiet: assert property (@(posedge clk) !rst_ok |=> !cyc_o && !stb_o) // see R23
    else $error("strobe or cycle high during reset");
  a_stb_in_cyc: assert property (@(posedge clk) disable iff (!rst_ok) stb_o |-> cyc_o) // see R10
    else $error("strobe without cycle");
  a_hold_stable: assert property (@(posedge clk) disable iff (!rst_ok)
    stb_o && !done_sig && (!s_q.pipe || stall_i) |=> $stable(adr_o) && $stable(dat_o) && $stable(sel_o) && $stable(we_o)) // see R24
    else $error("transfer changed while waiting");
  a_stall_hold: assert property (@(posedge clk) disable iff (!rst_ok)
    stb_o && s_q.pipe && stall_i && !done_sig |=> stb_o && $stable(adr_o)) // see R12
    else $error("stalled transfer dropped");
  a_we_stable: assert property (@(posedge clk) disable iff (!rst_ok) cyc_o && $past(cyc_o) |-> $stable(we_o)) // see R21
    else $error("write enable moved within cycle");
  a_tgc_stable: assert property (@(posedge clk) disable iff (!rst_ok) cyc_o && $past(cyc_o) |-> $stable(tgc_o)) // see R20
    else $error("cycle tag moved within cycle");
  a_err_ends: assert property (@(posedge clk) disable iff (!rst_ok) s_q.st == SBM_XFER && err_i |=> !cyc_o && done_valid && done_status == ST_ERR) // see R13
    else $error("error did not end cycle");
  a_rty_backoff: assert property (@(posedge clk) disable iff (!rst_ok)
    s_q.st == SBM_XFER && rty_i && !err_i && s_q.retries != RETRY_W'(RETRY_MAX) |=> !cyc_o ##1 cyc_o && stb_o) // see R15
    else $error("retry not replayed");
  a_ack_single: assert property (@(posedge clk) disable iff (!rst_ok)
    s_q.st == SBM_XFER && !s_q.pipe && ack_i && !err_i && !rty_i && s_q.left == '0 |=> !cyc_o && done_status == ST_OK) // see R8
    else $error("ack did not finish single");
  a_lock_in_cyc: assert property (@(posedge clk) disable iff (!rst_ok) lock_o |-> cyc_o) // see R14
    else $error("lock without cycle");

  // an accepted request opens the cycle on the very next edge
  a_start_cycle: assert property (@(posedge clk) disable iff (!rst_ok) // see R10
    req_ready && req_valid |=> cyc_o && stb_o)
    else $error("request did not open a cycle");

  // first beat carries exactly what the user handed over
  a_start_fields: assert property (@(posedge clk) disable iff (!rst_ok) // see R9
    req_ready && req_valid |=> adr_o == $past(req_adr) && we_o == $past(req_we) && sel_o == $past(req_sel))
    else $error("first beat fields differ from request");

  // address tag must not wander while the slave still owes an answer
  a_tga_hold: assert property (@(posedge clk) disable iff (!rst_ok) // see R19
    stb_o && !done_sig && (!s_q.pipe || stall_i) |=> $stable(tga_o))
    else $error("address tag moved while waiting");

  // data tag rides with write data, so it freezes with it
  a_tgd_hold: assert property (@(posedge clk) disable iff (!rst_ok) // see R7
    stb_o && !done_sig && (!s_q.pipe || stall_i) |=> $stable(tgd_o))
    else $error("data tag moved while waiting");

  // lock is only ever used for read-modify-write cycles
  a_lock_rmw: assert property (@(posedge clk) disable iff (!rst_ok) // see R14
    lock_o |-> tgc_o == TGC_RMW)
    else $error("lock outside read-modify-write");

  // classic burst: ack on a middle beat keeps the cycle and steps the address
  a_burst_step: assert property (@(posedge clk) disable iff (!rst_ok) // see R10
    s_q.st == SBM_XFER && !s_q.pipe && ack_i && !err_i && !rty_i && s_q.left != '0
    |=> cyc_o && stb_o && adr_o == $past(adr_o) + ADR_W'(1))
    else $error("burst did not advance");

  // every normal termination is reported once as ok
  a_ack_done: assert property (@(posedge clk) disable iff (!rst_ok) // see R8
    s_q.st == SBM_XFER && ack_i && !err_i && !rty_i |=> done_valid && done_status == ST_OK)
    else $error("ack not reported");

  // retries are bounded so a dead slave cannot hang the user side
  a_rty_limit: assert property (@(posedge clk) disable iff (!rst_ok) // see R15
    s_q.st == SBM_XFER && rty_i && !err_i && s_q.retries == RETRY_W'(RETRY_MAX)
    |=> !cyc_o && done_valid && done_status == ST_RETRY)
    else $error("retry limit not reported");

  // a replay restarts from the saved first address, not where it stopped
  a_replay_adr: assert property (@(posedge clk) disable iff (!rst_ok) // see R15
    s_q.st == SBM_BACKOFF |=> cyc_o && adr_o == $past(s_q.adr0))
    else $error("replay from wrong address");

  // an idle port neither requests the bus nor strobes
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_ok) // see R11
    req_ready |-> !cyc_o && !stb_o)
    else $error("idle port still on the bus");

  // pipelined: a taken beat is followed at once by the next address
  a_pipe_step: assert property (@(posedge clk) disable iff (!rst_ok) // see R12
    s_q.st == SBM_XFER && s_q.pipe && accept && !err_i && !rty_i && s_q.left != '0
    |=> stb_o && adr_o == $past(adr_o) + ADR_W'(1))
    else $error("pipelined beat not advanced");

  // read data and its tag are captured at the terminating edge
  a_read_capture: assert property (@(posedge clk) disable iff (!rst_ok) // see R7
    s_q.st == SBM_XFER && done_sig |=> done_dat == $past(dat_i) && done_tgd == $past(tgd_i))
    else $error("read data not captured");

  // reset returns the sequencer to idle with lock released
  a_reset_idle: assert property (@(posedge clk) // see R5
    !rst_ok |=> req_ready && !lock_o)
    else $error("reset did not idle the port");

  // no stale completion may leak out of a reset
  a_reset_done: assert property (@(posedge clk) // see R22
    !rst_ok |=> !done_valid)
    else $error("completion during reset");
endmodule : sbm_master
`default_nettype wire

// file: bench/sbm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side slave: one termination per strobe after a set delay
module sbm_slave_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic [29:0] adr,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  dly,
  input  wire logic        stall_en,
  output logic      [31:0] dat,
  output logic      [3:0]  tgd,
  output logic             ack,
  output logic             err,
  output logic             rty,
  output logic             stall,
  output int               starts
);
  logic [1:0]  wait_q;
  logic        cyc_q;
  logic        go;
  logic [31:0] rd;
  // never answer while an answer shows or while stalled
  assign go = stb && !(ack || err || rty) && !stall && wait_q == dly;
  assign rd = {adr, 2'b00} ^ 32'h5A5A_A5A5;
  // all answers registered, so stable before the sampling edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {dat, tgd, ack, err, rty, stall, wait_q, cyc_q} <= '0;
      starts <= 0;
    end else begin
      ack <= go && mode == 2'h0;
      err <= go && mode == 2'h1;
      rty <= go && mode == 2'h2;
      stall <= stall_en && !stall;
      wait_q <= (!stb || go) ? 2'h0 : (wait_q == dly ? wait_q : wait_q + 2'h1);
      cyc_q <= cyc;
      if (cyc && !cyc_q) starts <= starts + 1;
      // idle data flips each cycle so a stale sample never matches
      dat <= go ? rd : ~dat;
      tgd <= go ? {^rd[31:24], ^rd[23:16], ^rd[15:8], ^rd[7:0]} : ~tgd;
    end
  end
endmodule : sbm_slave_model
`default_nettype wire

// file: bench/soc_bus_master_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module soc_bus_master_port_tb;
  import sbm_pkg::*;
  logic        clk, rst_n, req_valid, req_ready, req_we, req_lock, pipe_mode, stall_en;
  logic        done_valid, ack_i, err_i, rty_i, stall_i, cyc_o, stb_o, we_o, lock_o, p_stb, p_stall;
  logic [29:0] req_adr, adr_o, p_adr;
  logic [31:0] req_dat, dat_o, dat_i, done_dat, exp_rd;
  logic [3:0]  req_sel, sel_o, tgd_i, tgd_o, done_tgd, req_len;
  logic [1:0]  req_tga, tga_o, tgc_o, done_status, mode, dly, last_st;
  logic [3:0]  ln;
  int          seed = 44, failures = 0, checks = 0, ndone = 0, starts, beat = 0, rcnt = 0, i;

  sbm_master DUT (.clk, .rst_n, .req_valid, .req_ready, .req_we, .req_adr, .req_dat, .req_sel,
    .req_tga, .req_len, .req_lock, .pipe_mode, .done_valid, .done_status, .done_dat, .done_tgd,
    .dat_i, .tgd_i, .ack_i, .err_i, .rty_i, .stall_i, .dat_o, .tgd_o, .adr_o, .sel_o, .tga_o,
    .tgc_o, .cyc_o, .stb_o, .we_o, .lock_o);
  sbm_slave_model slv (.clk, .rst_n, .cyc(cyc_o), .stb(stb_o), .adr(adr_o), .mode, .dly, .stall_en,
    .dat(dat_i), .tgd(tgd_i), .ack(ack_i), .err(err_i), .rty(rty_i), .stall(stall_i), .starts);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [3:0] par(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : par

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results;
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // watcher: every non-pipelined beat against the held request
  always @(posedge clk) begin
    rcnt <= rst_n ? 0 : rcnt + 1;
    if (rcnt >= 2) chk("cyc_o reset", {stb_o, cyc_o}, 2'b00);
    if (rst_n && cyc_o) begin
      chk("tgc_o", tgc_o, req_lock ? TGC_RMW : (req_len != 0 ? TGC_BLOCK : TGC_SINGLE));
      chk("lock_o", lock_o, req_lock);
      chk("we_o", we_o, req_we);
    end
    if (rst_n && stb_o && !pipe_mode) begin
      chk("adr_o", adr_o, 30'(req_adr + beat));
      chk("sel_o", sel_o, req_sel);
      chk("tga_o", tga_o, req_tga);
      if (req_we) chk("dat_o", dat_o, req_dat);
      if (req_we) chk("tgd_o", tgd_o, par(req_dat));
    end
    // a stalled beat must stay presented unchanged
    if (rst_n && p_stb && p_stall) chk("stalled", {stb_o, adr_o}, {1'b1, p_adr});
    p_stb <= stb_o;
    p_stall <= stall_i;
    p_adr <= adr_o;
    if (!cyc_o) beat <= 0;
    else if (cyc_o && ack_i) beat <= beat + 1;
    // pipelined acks arrive after strobe drops, so key on cycle
    if (cyc_o && ack_i) exp_rd <= {30'(req_adr + beat), 2'b00} ^ 32'h5A5A_A5A5;
    if (done_valid) begin
      ndone <= ndone + 1;
      last_st <= done_status;
      if (!req_we && done_status === ST_OK) chk("done_dat", {done_tgd, done_dat}, {par(exp_rd), exp_rd});
    end
  end

  // one request; expects nb completions, ns cycle starts, final status st
  task automatic run(input logic w, input logic [3:0] len, input logic lk, input logic pp,
                     input logic [1:0] md, input int nb, input int ns, input logic [1:0] st);
    int n0;
    int s0;
    int k;
    n0 = ndone;
    s0 = starts;
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_we <= w;
    req_len <= len;
    req_lock <= lk;
    req_adr <= 30'($random(seed));
    req_dat <= $random(seed);
    req_sel <= 4'($random(seed));
    req_tga <= 2'($random(seed));
    pipe_mode <= pp;
    stall_en <= pp;
    mode <= md;
    // hold the request until an edge that finds the port idle, then drop it
    do begin
      @(negedge clk);
      k++;
    end while (!req_ready && k < 50);
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    while (ndone - n0 < nb && k < 300) begin
      @(negedge clk);
      k++;
    end
    repeat (3) @(negedge clk);
    chk("done count", ndone - n0, nb);
    chk("cycles", starts - s0, ns);
    chk("status", last_st, st);
    chk("req_ready", req_ready, 1'b1);
  endtask : run

  initial begin
    {rst_n, req_valid, req_we, req_lock, pipe_mode, stall_en} = '0;
    {req_adr, req_dat, req_sel, req_tga, req_len, mode, dly} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 14; i++) begin
      dly <= 2'($random(seed));
      ln = 4'($random(seed) & 3);
      run(1'($random(seed)), ln, 1'($random(seed)), 1'b0, 2'h0, ln + 1, 1, ST_OK);
    end
    run(1'b0, 4'h2, 1'b0, 1'b0, 2'h1, 1, 1, ST_ERR);
    run(1'b1, 4'h0, 1'b0, 1'b0, 2'h2, 1, RETRY_MAX + 1, ST_RETRY);
    dly <= 2'h0;
    for (i = 0; i < 2; i++) run(1'(i), 4'h0, 1'b0, 1'b1, 2'h0, 1, 1, ST_OK);
    // reset in mid-cycle, then a clean restart
    @(posedge clk);
    dly <= 2'h3;
    pipe_mode <= 1'b0;
    stall_en <= 1'b0;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(1'b0, 4'h1, 1'b0, 1'b0, 2'h0, 2, 1, ST_OK);
    results();
  end

  initial begin
    #2000000;
    failures++;
    results();
  end
endmodule : soc_bus_master_port_tb
`default_nettype wire
